// File: verilog/fcpm_defs.svh
`ifndef FCPM_DEFS_SVH
`define FCPM_DEFS_SVH

`define FCPM_IMG_MAX    1060
`define FCPM_IMG_AW     11
`define FCPM_MAP_DEPTH  128
`define FCPM_MAP_AW     7
`define FCPM_PDO_SLOTS  16
`define FCPM_SLOT_W     4
`define FCPM_PDO_BYTES  8
`define FCPM_COB_MIN    11'h101
`define FCPM_COB_MAX    11'h580
`define FCPM_COB_NONE   11'h000
`define FCPM_MULTI_MAX  5'h1f
`define FCPM_DIR_RX     1'b0
`define FCPM_DIR_TX     1'b1

`endif

// File: verilog/fcpm_pkg.sv
`include "fcpm_defs.svh"

package fcpm_pkg;

  typedef enum logic [1:0] {
    FCPM_OP_SLOT,
    FCPM_OP_MAP,
    FCPM_OP_CLEAR
  } fcpm_op_t;

  typedef struct packed {
    logic [`FCPM_SLOT_W-1:0] slot;
    logic [2:0]              pbyte;
    logic [`FCPM_IMG_AW-1:0] pos;
  } fcpm_entry_t;

  typedef enum {
    ST_IDLE,
    ST_CFG_SCAN,
    ST_CFG_CHK,
    ST_CFG_END,
    ST_RX_RD,
    ST_RX_CHK,
    ST_TX_PICK,
    ST_TX_RD,
    ST_TX_CHK,
    ST_TX_PUT,
    ST_TX_OUT
  } fcpm_state_t;

endpackage

// File: verilog/fcpm_image_ram.sv
`include "fcpm_defs.svh"

module fcpm_image_ram #(
  parameter int DEPTH = `FCPM_IMG_MAX,
  parameter int AW    = `FCPM_IMG_AW
) (
  input  wire logic          i_core_clk,
  input  wire logic          i_we,
  input  wire logic [AW-1:0] i_waddr,
  input  wire logic [7:0]    i_wdata,
  input  wire logic [AW-1:0] i_raddr,
  output logic      [7:0]    o_rdata
);

  logic [7:0] mem [DEPTH];
  logic [7:0] rdata_nxt;

  // out-of-range reads give zero instead of aliasing
  always_comb begin
    rdata_nxt = 8'h00;
    if (i_raddr < AW'(DEPTH)) begin
      rdata_nxt = mem[i_raddr];
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_we && (i_waddr < AW'(DEPTH))) begin
      mem[i_waddr] <= i_wdata;
    end
    o_rdata <= rdata_nxt;
  end

endmodule

// File: verilog/fcpm_map_table.sv
`include "fcpm_defs.svh"

module fcpm_map_table import fcpm_pkg::*; #(
  parameter int DEPTH = `FCPM_MAP_DEPTH,
  parameter int AW    = `FCPM_MAP_AW
) (
  input  wire logic          i_core_clk,
  input  wire logic          i_nrst,
  input  wire logic          i_clear,
  input  wire logic          i_we,
  input  wire logic [AW-1:0] i_waddr,
  input  wire fcpm_entry_t   i_wentry,
  input  wire logic [AW-1:0] i_raddr,
  output logic               o_rvld,
  output fcpm_entry_t        o_rentry
);

  fcpm_entry_t      mem [DEPTH];
  logic [DEPTH-1:0] vld_r;
  logic [DEPTH-1:0] vld_nxt;

  // valid bits need a reset, the entry bodies do not
  always_comb begin
    vld_nxt = vld_r;
    if (i_clear) begin
      vld_nxt = '0;
    end else if (i_we) begin
      vld_nxt[i_waddr] = 1'b1;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      vld_r  <= '0;
      o_rvld <= 1'b0;
    end else begin
      vld_r  <= vld_nxt;
      o_rvld <= vld_r[i_raddr];
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wentry;
    end
    o_rentry <= mem[i_raddr];
  end

endmodule

// File: verilog/fcpm_mapper.sv
`include "fcpm_defs.svh"

// How it works
// - input and output images hold at most 1060 bytes, length set per side.
// - a pdo frame carries at most 8 payload bytes, 10 bytes overall.
// - no process data moves before startup has completed.
// - transfers run only while the fieldbus side is in data exchange.
// - master on the pdo side, slave on the fieldbus image side.
// - mappings apply both ways, pdo to input image and output image to pdo.
// - each entry ties one pdo byte of a cob-id to one image byte.
// - 128 receive plus 128 transmit entries, all data carried as pdos.
// - at most 16 transmit and 16 receive pdos.
// - at most 8 entries per pdo, 8 data bytes each.
// - one received pdo byte may land on several image positions.
// - image bytes feeding several pdo bytes, at most 31 such extra mappings.
// - pdo cob-ids must lie in 101h..580h, others refused.
module fcpm_mapper import fcpm_pkg::*; #(
  parameter int IMG_MAX   = `FCPM_IMG_MAX,
  parameter int MAP_DEPTH = `FCPM_MAP_DEPTH,
  parameter int PDO_BYTES = `FCPM_PDO_BYTES
) (
  input  wire logic                    i_core_clk,
  input  wire logic                    i_nrst,
  input  wire logic                    i_startup_done,
  input  wire logic                    i_fb_exchange,
  input  wire logic [`FCPM_IMG_AW-1:0] i_in_len,
  input  wire logic [`FCPM_IMG_AW-1:0] i_out_len,
  input  wire logic                    i_cfg_en,
  input  wire fcpm_op_t                i_cfg_op,
  input  wire logic                    i_cfg_dir,
  input  wire logic [`FCPM_MAP_AW-1:0] i_cfg_idx,
  input  wire logic [`FCPM_SLOT_W-1:0] i_cfg_slot,
  input  wire logic [10:0]             i_cfg_cob,
  input  wire logic [2:0]              i_cfg_byte,
  input  wire logic [`FCPM_IMG_AW-1:0] i_cfg_pos,
  output logic                         o_cfg_ready,
  output logic                         o_cfg_ack,
  output logic                         o_cfg_err,
  input  wire logic                    i_fb_wr_en,
  input  wire logic [`FCPM_IMG_AW-1:0] i_fb_wr_addr,
  input  wire logic [7:0]              i_fb_wr_data,
  input  wire logic [`FCPM_IMG_AW-1:0] i_fb_rd_addr,
  output logic      [7:0]              o_fb_rd_data,
  input  wire logic                    i_rx_valid,
  output logic                         o_rx_ready,
  input  wire logic [10:0]             i_rx_cob,
  input  wire logic [3:0]              i_rx_dlc,
  input  wire logic [63:0]             i_rx_data,
  output logic                         o_tx_valid,
  input  wire logic                    i_tx_ready,
  output logic      [10:0]             o_tx_cob,
  output logic      [3:0]              o_tx_dlc,
  output logic      [63:0]             o_tx_data,
  output logic                         o_active
);

  localparam logic [`FCPM_MAP_AW-1:0] IDX_LAST = `FCPM_MAP_AW'(MAP_DEPTH - 1);
  localparam logic [3:0]              BYTES_MAX = 4'(PDO_BYTES);

  fcpm_state_t                st_r, st_nxt;
  logic [`FCPM_MAP_AW-1:0]    idx_r, idx_nxt;
  logic [10:0]                slot_cob_r [2][`FCPM_PDO_SLOTS];
  logic [10:0]                slot_cob_nxt [2][`FCPM_PDO_SLOTS];
  logic [3:0]                 slot_cnt_r [2][`FCPM_PDO_SLOTS];
  logic [3:0]                 slot_cnt_nxt [2][`FCPM_PDO_SLOTS];
  logic [4:0]                 multi_r, multi_nxt;
  logic                       occ_r, occ_nxt, dup_r, dup_nxt;
  logic                       cfg_dir_r, cfg_dir_nxt;
  logic [`FCPM_MAP_AW-1:0]    cfg_idx_r, cfg_idx_nxt;
  fcpm_entry_t                cfg_ent_r, cfg_ent_nxt;
  logic [10:0]                rx_cob_r, rx_cob_nxt;
  logic [3:0]                 rx_dlc_r, rx_dlc_nxt;
  logic [63:0]                rx_data_r, rx_data_nxt;
  logic [`FCPM_SLOT_W-1:0]    tx_slot_r, tx_slot_nxt;
  logic [2:0]                 sel_r, sel_nxt;
  logic [63:0]                buf_r, buf_nxt;
  logic [3:0]                 blen_r, blen_nxt;
  logic                       tx_valid_nxt, ack_nxt, err_nxt;
  logic [10:0]                tx_cob_nxt;
  logic [3:0]                 tx_dlc_nxt;
  logic [63:0]                tx_data_nxt;
  logic                       active_r, active_nxt, rx_ready_nxt, cfg_ready_nxt;
  logic                       tbl_clear, rx_tbl_we, tx_tbl_we;
  logic                       rx_vld, tx_vld, ent_vld, in_we, cfg_bad;
  fcpm_entry_t                rx_ent, tx_ent, ent;
  logic [7:0]                 out_rdata;

  fcpm_map_table u_rx_tbl (
    .i_core_clk (i_core_clk),
    .i_nrst     (i_nrst),
    .i_clear    (tbl_clear),
    .i_we       (rx_tbl_we),
    .i_waddr    (cfg_idx_r),
    .i_wentry   (cfg_ent_r),
    .i_raddr    (idx_r),
    .o_rvld     (rx_vld),
    .o_rentry   (rx_ent)
  );

  fcpm_map_table u_tx_tbl (
    .i_core_clk (i_core_clk),
    .i_nrst     (i_nrst),
    .i_clear    (tbl_clear),
    .i_we       (tx_tbl_we),
    .i_waddr    (cfg_idx_r),
    .i_wentry   (cfg_ent_r),
    .i_raddr    (idx_r),
    .o_rvld     (tx_vld),
    .o_rentry   (tx_ent)
  );

  // input image: written by the rx mapping, read by the scanner
  fcpm_image_ram #(.DEPTH(IMG_MAX)) u_in_img (
    .i_core_clk (i_core_clk),
    .i_we       (in_we),
    .i_waddr    (ent.pos),
    .i_wdata    (rx_data_r[{ent.pbyte, 3'b000} +: 8]),
    .i_raddr    (i_fb_rd_addr),
    .o_rdata    (o_fb_rd_data)
  );

  // output image: written by the scanner within its current length
  fcpm_image_ram #(.DEPTH(IMG_MAX)) u_out_img (
    .i_core_clk (i_core_clk),
    .i_we       (i_fb_wr_en && (i_fb_wr_addr < i_out_len)),
    .i_waddr    (i_fb_wr_addr),
    .i_wdata    (i_fb_wr_data),
    .i_raddr    (ent.pos),
    .o_rdata    (out_rdata)
  );

  // one read port set per table, the state picks which entry is looked at
  assign ent_vld = (st_r == ST_TX_CHK) ? tx_vld : (st_r == ST_CFG_CHK && cfg_dir_r) ? tx_vld : rx_vld;
  assign ent     = (st_r == ST_TX_CHK) ? tx_ent : (st_r == ST_CFG_CHK && cfg_dir_r) ? tx_ent : rx_ent;
  assign in_we   = (st_r == ST_RX_CHK) && active_r && ent_vld
                   && (slot_cob_r[`FCPM_DIR_RX][ent.slot] == rx_cob_r)
                   && ({1'b0, ent.pbyte} < rx_dlc_r) && (ent.pos < i_in_len);

  always_comb begin
    st_nxt        = st_r;
    idx_nxt       = idx_r;
    slot_cob_nxt  = slot_cob_r;
    slot_cnt_nxt  = slot_cnt_r;
    multi_nxt     = multi_r;
    occ_nxt       = occ_r;
    dup_nxt       = dup_r;
    cfg_dir_nxt   = cfg_dir_r;
    cfg_idx_nxt   = cfg_idx_r;
    cfg_ent_nxt   = cfg_ent_r;
    rx_cob_nxt    = rx_cob_r;
    rx_dlc_nxt    = rx_dlc_r;
    rx_data_nxt   = rx_data_r;
    tx_slot_nxt   = tx_slot_r;
    sel_nxt       = sel_r;
    buf_nxt       = buf_r;
    blen_nxt      = blen_r;
    tx_valid_nxt  = o_tx_valid && !i_tx_ready;
    tx_cob_nxt    = o_tx_cob;
    tx_dlc_nxt    = o_tx_dlc;
    tx_data_nxt   = o_tx_data;
    ack_nxt       = 1'b0;
    err_nxt       = o_cfg_err;
    tbl_clear     = 1'b0;
    rx_tbl_we     = 1'b0;
    tx_tbl_we     = 1'b0;
    cfg_bad       = 1'b0;
    active_nxt    = i_startup_done && i_fb_exchange;
    unique case (st_r)
      ST_IDLE: begin
        if (o_cfg_ready && i_cfg_en) begin
          cfg_dir_nxt = i_cfg_dir;
          cfg_idx_nxt = i_cfg_idx;
          cfg_ent_nxt = '{slot: i_cfg_slot, pbyte: i_cfg_byte, pos: i_cfg_pos};
          unique case (i_cfg_op)
            FCPM_OP_CLEAR: begin
              tbl_clear    = 1'b1;
              slot_cob_nxt = '{default: `FCPM_COB_NONE};
              slot_cnt_nxt = '{default: 4'h0};
              multi_nxt    = 5'h00;
              ack_nxt      = 1'b1;
              err_nxt      = 1'b0;
            end
            FCPM_OP_SLOT: begin
              // a slot keeps its cob-id while entries still point at it
              cfg_bad = (i_cfg_cob < `FCPM_COB_MIN) || (i_cfg_cob > `FCPM_COB_MAX)
                        || (slot_cnt_r[i_cfg_dir][i_cfg_slot] != 4'h0);
              if (!cfg_bad) begin
                slot_cob_nxt[i_cfg_dir][i_cfg_slot] = i_cfg_cob;
              end
              ack_nxt = 1'b1;
              err_nxt = cfg_bad;
            end
            FCPM_OP_MAP: begin
              occ_nxt = 1'b0;
              dup_nxt = 1'b0;
              idx_nxt = '0;
              st_nxt  = ST_CFG_SCAN;
            end
            default: begin
              ack_nxt = 1'b1;
              err_nxt = 1'b1;
            end
          endcase
        end else if (o_rx_ready && i_rx_valid) begin
          if (i_rx_dlc <= BYTES_MAX) begin
            rx_cob_nxt  = i_rx_cob;
            rx_dlc_nxt  = i_rx_dlc;
            rx_data_nxt = i_rx_data;
            idx_nxt     = '0;
            st_nxt      = ST_RX_RD;
          end
        end else if (active_r && !o_tx_valid) begin
          st_nxt = ST_TX_PICK;
        end
      end
      ST_CFG_SCAN: st_nxt = ST_CFG_CHK;
      ST_CFG_CHK: begin
        if (ent_vld && (idx_r == cfg_idx_r)) begin
          occ_nxt = 1'b1;
        end
        if (ent_vld && cfg_dir_r && (ent.pos == cfg_ent_r.pos)) begin
          dup_nxt = 1'b1;
        end
        idx_nxt = idx_r + 1'b1;
        st_nxt  = (idx_r == IDX_LAST) ? ST_CFG_END : ST_CFG_SCAN;
      end
      ST_CFG_END: begin
        cfg_bad = occ_r || (cfg_ent_r.pos >= `FCPM_IMG_AW'(IMG_MAX))
                  || (slot_cob_r[cfg_dir_r][cfg_ent_r.slot] == `FCPM_COB_NONE)
                  || (slot_cnt_r[cfg_dir_r][cfg_ent_r.slot] >= BYTES_MAX)
                  || (dup_r && (multi_r == `FCPM_MULTI_MAX));
        if (!cfg_bad) begin
          rx_tbl_we = !cfg_dir_r;
          tx_tbl_we = cfg_dir_r;
          slot_cnt_nxt[cfg_dir_r][cfg_ent_r.slot] = slot_cnt_r[cfg_dir_r][cfg_ent_r.slot] + 4'h1;
          if (dup_r) begin
            multi_nxt = multi_r + 5'h01;
          end
        end
        ack_nxt = 1'b1;
        err_nxt = cfg_bad;
        st_nxt  = ST_IDLE;
      end
      ST_RX_RD: st_nxt = ST_RX_CHK;
      ST_RX_CHK: begin
        // every entry is visited, so one pdo byte may fill several positions
        idx_nxt = idx_r + 1'b1;
        st_nxt  = (!active_r || idx_r == IDX_LAST) ? ST_IDLE : ST_RX_RD;
      end
      ST_TX_PICK: begin
        if (!active_r) begin
          st_nxt = ST_IDLE;
        end else if (slot_cnt_r[`FCPM_DIR_TX][tx_slot_r] != 4'h0) begin
          buf_nxt  = 64'h0;
          blen_nxt = 4'h0;
          idx_nxt  = '0;
          st_nxt   = ST_TX_RD;
        end else begin
          tx_slot_nxt = tx_slot_r + 1'b1;
          st_nxt      = ST_IDLE;
        end
      end
      ST_TX_RD: st_nxt = ST_TX_CHK;
      ST_TX_CHK: begin
        idx_nxt = idx_r + 1'b1;
        st_nxt  = (idx_r == IDX_LAST) ? ST_TX_OUT : ST_TX_RD;
        if (!active_r) begin
          st_nxt = ST_IDLE;
        end else if (tx_vld && (tx_ent.slot == tx_slot_r) && (tx_ent.pos < i_out_len)) begin
          sel_nxt = tx_ent.pbyte;
          st_nxt  = ST_TX_PUT;
        end
      end
      ST_TX_PUT: begin
        buf_nxt[{sel_r, 3'b000} +: 8] = out_rdata;
        if ({1'b0, sel_r} >= blen_r) begin
          blen_nxt = {1'b0, sel_r} + 4'h1;
        end
        st_nxt = !active_r ? ST_IDLE : (idx_r == '0) ? ST_TX_OUT : ST_TX_RD;
      end
      ST_TX_OUT: begin
        // a pdo whose bytes all lie past the image length is not sent
        if (blen_r != 4'h0) begin
          tx_valid_nxt = 1'b1;
          tx_cob_nxt   = slot_cob_r[`FCPM_DIR_TX][tx_slot_r];
          tx_dlc_nxt   = blen_r;
          tx_data_nxt  = buf_r;
        end
        tx_slot_nxt = tx_slot_r + 1'b1;
        st_nxt      = ST_IDLE;
      end
    endcase
    cfg_ready_nxt = (st_nxt == ST_IDLE) && !i_startup_done;
    rx_ready_nxt  = (st_nxt == ST_IDLE) && active_nxt;
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      st_r        <= ST_IDLE;
      idx_r       <= '0;
      slot_cob_r  <= '{default: `FCPM_COB_NONE};
      slot_cnt_r  <= '{default: 4'h0};
      multi_r     <= 5'h00;
      occ_r       <= 1'b0;
      dup_r       <= 1'b0;
      cfg_dir_r   <= `FCPM_DIR_RX;
      cfg_idx_r   <= '0;
      cfg_ent_r   <= '0;
      rx_cob_r    <= 11'h000;
      rx_dlc_r    <= 4'h0;
      rx_data_r   <= 64'h0;
      tx_slot_r   <= '0;
      sel_r       <= 3'h0;
      buf_r       <= 64'h0;
      blen_r      <= 4'h0;
      o_tx_valid  <= 1'b0;
      o_tx_cob    <= 11'h000;
      o_tx_dlc    <= 4'h0;
      o_tx_data   <= 64'h0;
      o_cfg_ack   <= 1'b0;
      o_cfg_err   <= 1'b0;
      o_cfg_ready <= 1'b0;
      o_rx_ready  <= 1'b0;
      active_r    <= 1'b0;
    end else begin
      st_r        <= st_nxt;
      idx_r       <= idx_nxt;
      slot_cob_r  <= slot_cob_nxt;
      slot_cnt_r  <= slot_cnt_nxt;
      multi_r     <= multi_nxt;
      occ_r       <= occ_nxt;
      dup_r       <= dup_nxt;
      cfg_dir_r   <= cfg_dir_nxt;
      cfg_idx_r   <= cfg_idx_nxt;
      cfg_ent_r   <= cfg_ent_nxt;
      rx_cob_r    <= rx_cob_nxt;
      rx_dlc_r    <= rx_dlc_nxt;
      rx_data_r   <= rx_data_nxt;
      tx_slot_r   <= tx_slot_nxt;
      sel_r       <= sel_nxt;
      buf_r       <= buf_nxt;
      blen_r      <= blen_nxt;
      o_tx_valid  <= tx_valid_nxt;
      o_tx_cob    <= tx_cob_nxt;
      o_tx_dlc    <= tx_dlc_nxt;
      o_tx_data   <= tx_data_nxt;
      o_cfg_ack   <= ack_nxt;
      o_cfg_err   <= err_nxt;
      o_cfg_ready <= cfg_ready_nxt;
      o_rx_ready  <= rx_ready_nxt;
      active_r    <= active_nxt;
    end
  end

  assign o_active = active_r;

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);

  sequence seq_slot_bad;
    o_cfg_ready && i_cfg_en && (i_cfg_op == FCPM_OP_SLOT)
      && ((i_cfg_cob < `FCPM_COB_MIN) || (i_cfg_cob > `FCPM_COB_MAX));
  endsequence

  sequence seq_rx_long;
    o_rx_ready && i_rx_valid && (i_rx_dlc > BYTES_MAX);
  endsequence

  chk_img_write_gate: assert property (in_we |-> active_r && $past(i_startup_done))
    else $error("input image written before startup completed");
  chk_tx_start_gate: assert property ($rose(o_tx_valid) |-> $past(active_r, 2))
    else $error("pdo raised outside data exchange");
  chk_tx_hold_frame: assert property (o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_cob)
                                      && $stable(o_tx_data))
    else $error("pdo dropped or changed before it was taken");
  chk_tx_cob_range: assert property (o_tx_valid |-> o_tx_cob >= `FCPM_COB_MIN && o_tx_cob <= `FCPM_COB_MAX)
    else $error("pdo sent with cob-id out of range");
  chk_slot_cob_refuse: assert property (seq_slot_bad |=> o_cfg_ack && o_cfg_err)
    else $error("out of range cob-id accepted");
  chk_tx_dlc_max: assert property (o_tx_valid |-> o_tx_dlc != 4'h0 && o_tx_dlc <= BYTES_MAX)
    else $error("pdo length outside 1..8");
  chk_rx_long_drop: assert property (seq_rx_long |=> !in_we [*3])
    else $error("over-long frame reached the image");
  chk_multi_limit: assert property (multi_r <= `FCPM_MULTI_MAX && $past(multi_r) <= multi_r + 5'h00
                                    || $past(st_r) == ST_IDLE)
    else $error("multiple mapping count out of bounds");
  chk_pdo_entry_cap: assert property (slot_cnt_r[`FCPM_DIR_TX][tx_slot_r] <= BYTES_MAX
                                      && slot_cnt_r[`FCPM_DIR_RX][tx_slot_r] <= BYTES_MAX)
    else $error("more than eight entries on one pdo");
  chk_img_len_bound: assert property (in_we |-> ent.pos < i_in_len)
    else $error("input image written past its length");

endmodule

// File: tb/fcpm_can_node.sv
module fcpm_can_node (
  input  wire logic        i_core_clk,
  input  wire logic        i_rx_ready,
  input  wire logic        i_tx_valid,
  input  wire logic [10:0] i_tx_cob,
  input  wire logic [3:0]  i_tx_dlc,
  input  wire logic [63:0] i_tx_data,
  output logic             o_rx_valid,
  output logic [10:0]      o_rx_cob,
  output logic [3:0]       o_rx_dlc,
  output logic [63:0]      o_rx_data,
  output logic             o_tx_ready
);
  timeunit 1ns;
  timeprecision 100ps;
  int          stall = 0;
  int          frames = 0;
  int          wait_cnt = 0;
  bit          moved = 0;
  bit          held = 0;
  logic [78:0] prev_frame = '0;
  logic [10:0] last_cob = '0;
  logic [3:0]  last_dlc = '0;
  logic [63:0] last_data = '0;

  initial begin
    o_rx_valid = 1'b0;
    o_rx_cob = 11'h000;
    o_rx_dlc = 4'h0;
    o_rx_data = 64'h0;
    o_tx_ready = 1'b0;
  end

  // a busy node: accept an offered pdo only after stall cycles
  always @(posedge i_core_clk) begin
    prev_frame <= {i_tx_cob, i_tx_dlc, i_tx_data};
    held <= i_tx_valid && !o_tx_ready;
    if (held && i_tx_valid && ({i_tx_cob, i_tx_dlc, i_tx_data} !== prev_frame)) begin
      moved <= 1'b1;
    end
    if (i_tx_valid && o_tx_ready) begin
      last_cob <= i_tx_cob;
      last_dlc <= i_tx_dlc;
      last_data <= i_tx_data;
      frames <= frames + 1;
      o_tx_ready <= 1'b0;
      wait_cnt <= 0;
    end else if (i_tx_valid) begin
      wait_cnt <= wait_cnt + 1;
      o_tx_ready <= (wait_cnt >= stall);
    end
  end

  // offer one frame, hold it until taken, then scramble the released lines
  task automatic send(input logic [10:0] cob, input logic [3:0] dlc, input logic [63:0] data, output bit ok);
    int n;
    ok = 1'b0;
    n = 0;
    @(posedge i_core_clk);
    #2;
    o_rx_valid = 1'b1;
    o_rx_cob = cob;
    o_rx_dlc = dlc;
    o_rx_data = data;
    while (!ok && n < 1000) begin
      if (i_rx_ready === 1'b1) ok = 1'b1;
      @(posedge i_core_clk);
      #2;
      n++;
    end
    o_rx_valid = 1'b0;
    o_rx_cob = ~cob;
    o_rx_dlc = ~dlc;
    o_rx_data = ~data;
  endtask
endmodule

// File: tb/fcpm_mapper_bench.sv
module fcpm_mapper_bench import fcpm_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic        core_clk = 1'b0;
  logic        nrst = 1'b0;
  logic        startup_done = 1'b0;
  logic        fb_exchange = 1'b0;
  logic        cfg_en = 1'b0;
  fcpm_op_t    cfg_op = FCPM_OP_SLOT;
  logic        cfg_dir = 1'b0;
  logic [6:0]  cfg_idx = 7'h00;
  logic [3:0]  cfg_slot = 4'h0;
  logic [10:0] cfg_cob = 11'h000;
  logic [2:0]  cfg_byte = 3'h0;
  logic [10:0] cfg_pos = 11'h000;
  logic        fb_wr_en = 1'b0;
  logic [10:0] fb_wr_addr = 11'h000;
  logic [7:0]  fb_wr_data = 8'h00;
  logic [10:0] fb_rd_addr = 11'h000;
  logic [10:0] in_len = 11'h424;
  logic [10:0] out_len = 11'h424;
  logic        cfg_ready, cfg_ack, cfg_err, rx_ready, rx_valid, tx_valid, tx_ready, active;
  logic [7:0]  fb_rd_data;
  logic [10:0] rx_cob, tx_cob;
  logic [3:0]  rx_dlc, tx_dlc;
  logic [63:0] rx_data, tx_data;
  int          failures = 0;
  int          total_checks = 0;
  int          cycles = 0;

  fcpm_mapper u_fcpm_mapper (
    .i_core_clk(core_clk), .i_nrst(nrst), .i_startup_done(startup_done), .i_fb_exchange(fb_exchange),
    .i_in_len(in_len), .i_out_len(out_len), .i_cfg_en(cfg_en), .i_cfg_op(cfg_op), .i_cfg_dir(cfg_dir),
    .i_cfg_idx(cfg_idx), .i_cfg_slot(cfg_slot), .i_cfg_cob(cfg_cob), .i_cfg_byte(cfg_byte),
    .i_cfg_pos(cfg_pos), .o_cfg_ready(cfg_ready), .o_cfg_ack(cfg_ack), .o_cfg_err(cfg_err),
    .i_fb_wr_en(fb_wr_en), .i_fb_wr_addr(fb_wr_addr), .i_fb_wr_data(fb_wr_data),
    .i_fb_rd_addr(fb_rd_addr), .o_fb_rd_data(fb_rd_data), .i_rx_valid(rx_valid), .o_rx_ready(rx_ready),
    .i_rx_cob(rx_cob), .i_rx_dlc(rx_dlc), .i_rx_data(rx_data), .o_tx_valid(tx_valid),
    .i_tx_ready(tx_ready), .o_tx_cob(tx_cob), .o_tx_dlc(tx_dlc), .o_tx_data(tx_data), .o_active(active)
  );

  fcpm_can_node u_fcpm_can_node (
    .i_core_clk(core_clk), .i_rx_ready(rx_ready), .i_tx_valid(tx_valid), .i_tx_cob(tx_cob),
    .i_tx_dlc(tx_dlc), .i_tx_data(tx_data), .o_rx_valid(rx_valid), .o_rx_cob(rx_cob),
    .o_rx_dlc(rx_dlc), .o_rx_data(rx_data), .o_tx_ready(tx_ready)
  );

  always #12.5 core_clk = ~core_clk;

  task automatic conclude();
    if (failures == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // hang guard: the whole sequence needs well under 15000 cycles
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 40000) begin
      failures++;
      conclude();
    end
  end

  task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask

  task automatic cfg(input logic [1:0] op, input logic dir, input logic [6:0] idx, input logic [3:0] slot,
                     input logic [10:0] cob, input logic [2:0] pb, input logic [10:0] pos, input logic err);
    int n;
    n = 0;
    // an edge must pass so cfg_en is never lowered and raised in one step
    step(1);
    while (cfg_ready !== 1'b1 && n < 400) begin
      step(1);
      n++;
    end
    cfg_op = fcpm_op_t'(op);
    cfg_dir = dir;
    cfg_idx = idx;
    cfg_slot = slot;
    cfg_cob = cob;
    cfg_byte = pb;
    cfg_pos = pos;
    cfg_en = 1'b1;
    step(1);
    cfg_en = 1'b0;
    n = 0;
    while (cfg_ack !== 1'b1 && n < 300) begin
      step(1);
      n++;
    end
    cmp({cfg_ack, cfg_err}, {1'b1, err});
  endtask

  task automatic rd(input logic [10:0] addr, input logic [7:0] exp);
    fb_rd_addr = addr;
    step(1);
    cmp(fb_rd_data, exp);
  endtask

  task automatic frame(input logic [10:0] cob, input logic [3:0] dlc, input logic [63:0] data);
    bit ok;
    int n;
    n = 0;
    u_fcpm_can_node.send(cob, dlc, data, ok);
    cmp(ok, 1'b1);
    while (rx_ready !== 1'b1 && n < 600) begin
      step(1);
      n++;
    end
  endtask

  task automatic t_gate();
    logic seen;
    seen = 1'b0;
    fb_exchange = 1'b1;
    repeat (20) begin
      step(1);
      seen = seen | rx_ready | tx_valid | active;
    end
    cmp(seen, 1'b0);
    fb_exchange = 1'b0;
  endtask

  task automatic t_config();
    cfg(2'h2, 1'b0, 7'h00, 4'h0, 11'h000, 3'h0, 11'h000, 1'b0);
    cfg(2'h0, 1'b0, 7'h00, 4'h0, 11'h100, 3'h0, 11'h000, 1'b1);
    cfg(2'h0, 1'b0, 7'h00, 4'h0, 11'h581, 3'h0, 11'h000, 1'b1);
    cfg(2'h0, 1'b0, 7'h00, 4'h1, 11'h101, 3'h0, 11'h000, 1'b0);
    cfg(2'h0, 1'b0, 7'h00, 4'h2, 11'h580, 3'h0, 11'h000, 1'b0);
    cfg(2'h0, 1'b0, 7'h00, 4'h0, 11'h181, 3'h0, 11'h000, 1'b0);
    cfg(2'h0, 1'b1, 7'h00, 4'h0, 11'h201, 3'h0, 11'h000, 1'b0);
    cfg(2'h3, 1'b0, 7'h00, 4'h0, 11'h000, 3'h0, 11'h000, 1'b1);
    cfg(2'h1, 1'b0, 7'h05, 4'h3, 11'h000, 3'h0, 11'h005, 1'b1);
    cfg(2'h1, 1'b0, 7'h05, 4'h0, 11'h000, 3'h0, 11'h424, 1'b1);
  endtask

  task automatic t_maps();
    cfg(2'h1, 1'b0, 7'h00, 4'h0, 11'h000, 3'h1, 11'h007, 1'b0);
    cfg(2'h1, 1'b0, 7'h01, 4'h0, 11'h000, 3'h1, 11'h009, 1'b0);
    for (int k = 2; k < 8; k++) begin
      cfg(2'h1, 1'b0, 7'(k), 4'h0, 11'h000, 3'(k), 11'(20 + k), 1'b0);
    end
    cfg(2'h1, 1'b0, 7'h08, 4'h0, 11'h000, 3'h0, 11'h01e, 1'b1);
    cfg(2'h1, 1'b0, 7'h00, 4'h1, 11'h000, 3'h0, 11'h01f, 1'b1);
    cfg(2'h0, 1'b0, 7'h00, 4'h0, 11'h182, 3'h0, 11'h000, 1'b1);
    cfg(2'h1, 1'b1, 7'h00, 4'h0, 11'h000, 3'h0, 11'h003, 1'b0);
    cfg(2'h1, 1'b1, 7'h01, 4'h0, 11'h000, 3'h2, 11'h003, 1'b0);
  endtask

  task automatic t_tx();
    int n;
    logic seen;
    n = 0;
    seen = 1'b0;
    fb_wr_addr = 11'h003;
    fb_wr_data = 8'ha5;
    fb_wr_en = 1'b1;
    step(1);
    out_len = 11'h003;
    fb_wr_data = 8'h5a;
    step(1);
    fb_wr_en = 1'b0;
    out_len = 11'h424;
    startup_done = 1'b1;
    repeat (20) begin
      step(1);
      seen = seen | active | tx_valid | rx_ready;
    end
    cmp(seen, 1'b0);
    u_fcpm_can_node.stall = 5;
    fb_exchange = 1'b1;
    step(2);
    cmp(active, 1'b1);
    while (u_fcpm_can_node.frames == 0 && n < 3000) begin
      step(1);
      n++;
    end
    cmp(u_fcpm_can_node.last_cob, 11'h201);
    cmp(u_fcpm_can_node.last_dlc, 4'h3);
    cmp(u_fcpm_can_node.last_data, 64'h0000000000a500a5);
    cmp(u_fcpm_can_node.moved, 1'b0);
  endtask

  task automatic t_rx();
    frame(11'h181, 4'h8, 64'h8877665544332211);
    rd(11'h007, 8'h22);
    rd(11'h009, 8'h22);
    for (int k = 2; k < 8; k++) begin
      rd(11'(20 + k), 8'(k * 17 + 17));
    end
    frame(11'h182, 4'h8, 64'hffffffffffffffff);
    rd(11'h007, 8'h22);
    frame(11'h181, 4'h9, 64'hffffffffffffffff);
    rd(11'h007, 8'h22);
    frame(11'h181, 4'h2, 64'h000000000000cc00);
    rd(11'h007, 8'hcc);
    rd(11'h016, 8'h33);
    in_len = 11'h008;
    frame(11'h181, 4'h2, 64'h000000000000dd00);
    rd(11'h007, 8'hdd);
    rd(11'h009, 8'hcc);
    in_len = 11'h424;
  endtask

  task automatic t_stop();
    int snap;
    logic seen;
    seen = 1'b0;
    fb_exchange = 1'b0;
    step(20);
    snap = u_fcpm_can_node.frames;
    repeat (600) begin
      step(1);
      seen = seen | rx_ready | active;
    end
    cmp(seen, 1'b0);
    cmp(u_fcpm_can_node.frames - snap, 0);
  endtask

  initial begin
    step(12);
    nrst = 1'b1;
    step(1);
    t_gate();
    t_config();
    t_maps();
    t_tx();
    t_rx();
    t_stop();
    conclude();
  end
endmodule
